// File: pkg/cds_defines.svh
`ifndef CDS_DEFINES_SVH
`define CDS_DEFINES_SVH
`define CDS_OFF_CTRL 32'h0000_0000
`define CDS_OFF_LEVEL 32'h0000_0004
`define CDS_OFF_CMD 32'h0000_0008
`define CDS_OFF_FBINT 32'h0000_000c
`define CDS_OFF_STATUS 32'h0000_0010
`define CDS_CTRL_CODE 4:0
`define CDS_CTRL_SELA 6:5
`define CDS_CTRL_SELB 8:7
`define CDS_CTRL_ENA 9
`define CDS_CTRL_ENB 10
`define CDS_CTRL_PD 11
`define CDS_CTRL_CALPIN 12
`define CDS_CTRL_PMODE 13
`define CDS_CTRL_FRAC 14
`define CDS_CTRL_PULLUP 15
`define CDS_CTRL_BAND 17:16
`define CDS_CTRL_RST 32'h0000_17e0
`define CDS_LEVEL_A 5:0
`define CDS_LEVEL_B 13:8
`define CDS_LEVEL_RST 32'h0000_1414
`define CDS_CMD_CAL 0
`define CDS_CMD_SYNC 1
`define CDS_STAT_REJ 15
`define CDS_CODE_MAX 5'h0d
`define CDS_LVL_DUP_LO 6'h20
`define CDS_LVL_DUP_HI 6'h2f
`define CDS_LVL_31 6'h1f
`define CDS_LVL_20 6'h14
`define CDS_LVL_MAX 6'h3f
`define CDS_CLK_NS 25
`define CDS_CAL_NS 10000
`define CDS_SETTLE_NS 5000
`define CDS_MODW_NS 2000
`define CDS_CAL_CYC ((`CDS_CAL_NS + `CDS_CLK_NS - 1) / `CDS_CLK_NS)
`define CDS_SETTLE_CYC ((`CDS_SETTLE_NS + `CDS_CLK_NS - 1) / `CDS_CLK_NS)
`define CDS_MODW_CYC ((`CDS_MODW_NS + `CDS_CLK_NS - 1) / `CDS_CLK_NS)
`endif

// File: pkg/cds_pkg.sv
package cds_pkg;
    typedef enum logic [1:0] {
        cds_sel_out_divide_code,
        cds_sel_vco,
        cds_sel_sysref,
        cds_sel_off
    } cds_sel_t;
    typedef enum logic [2:0] {
        cds_st_idle,
        cds_st_cal,
        cds_st_settle,
        cds_st_modw,
        cds_st_done
    } cds_state_t;
endpackage

// File: pkg/cds_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cds_if;
    logic [4:0] out_divide_code;
    cds_pkg::cds_sel_t first_output_select;
    cds_pkg::cds_sel_t second_output_select;
    logic [5:0] level_a;
    logic [5:0] level_b;
    logic pd_bit;
    logic cal_pin;
    logic frac_mode;
    logic phase_mode;
    logic sync_pin_ignore;
    logic sync_pin;
    logic band_cal_trigger;
    logic [15:0] fb_int;
    logic powered_down;
    logic divider_powered;
    logic phase_det;
    logic need_recal;
    logic [7:0] ratio;
    logic [2:0] extra_div_calc;
    modport dev(input out_divide_code, first_output_select, second_output_select,
        level_a, level_b, pd_bit, cal_pin, frac_mode, phase_mode, sync_pin_ignore,
        sync_pin, band_cal_trigger, fb_int, output powered_down, divider_powered,
        phase_det, need_recal, ratio, extra_div_calc);
    modport host(output out_divide_code, first_output_select, second_output_select,
        level_a, level_b, pd_bit, cal_pin, frac_mode, phase_mode, sync_pin_ignore,
        sync_pin, band_cal_trigger, fb_int, input powered_down, divider_powered,
        phase_det, need_recal, ratio, extra_div_calc);
endinterface
`default_nettype wire

// File: core/cds_device.sv
// Behaviour
// - divider is product of four stages
// - codes 0..13 select tabulated stage factors
// - controller never programs codes 14..31
// - divider powered when either output needs it
// - unused outputs should select vco
// - level codes 32..47 repeat level 31
// - resistive pullup limits level to 31
// - 5 to 10 ghz limits level to 31
// - above 10 ghz limit level to 20
// - level changes never disturb lock state
// - power-down by bit or cal pin
// - controller recalibrates after leaving power-down
// - sync pulse retimed to next reference edge
// - phase deterministic after cal, settle, wait (code skips the wait unless frac_mode is set)
// - extra feedback divide 1, 6 or 4
// - software sync by mode bit rising
// - critical sync uses the sync pin
// - pin ignore set opposite to mode
// - feedback value divided before mode enable
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cds_defines.svh"
module cds_device (
    input wire logic aclk,
    input wire logic aresetn,
    cds_if.dev link,
    output logic [3:0] stage_a_factor,
    output logic [3:0] stage_b_factor,
    output logic [3:0] stage_c_factor,
    output logic [3:0] stage_d_factor,
    output logic [7:0] divide_ratio,
    output logic divider_power,
    output logic [5:0] out_level_a,
    output logic [5:0] out_level_b,
    output logic device_powered_down,
    output logic sync_pulse,
    output logic [2:0] feedback_extra_divide,
    output logic phase_deterministic
);
    ////////////////////////////////////////////////////////////////////////
    // divider decode; each entry packs stage b, c, d factors
    localparam logic [11:0] STAGE_ROM [14] = '{
        12'h111, 12'h211, 12'h311, 12'h221, 12'h321, 12'h241, 12'h341,
        12'h281, 12'h381, 12'h282, 12'h362, 12'h382, 12'h284, 12'h384
    };
    localparam int SEQ_W = 9;
    wire logic code_ok;
    wire logic [11:0] stage_word;
    wire logic [3:0] sa, sb, sc, sd;
    wire logic [7:0] ratio_w;
    // invalid codes give zero factors rather than a guessed ratio
    assign code_ok = link.out_divide_code <= `CDS_CODE_MAX;
    assign stage_word = code_ok ? STAGE_ROM[link.out_divide_code[3:0]] : 12'h000;
    assign sa = code_ok ? 4'h2 : 4'h0;
    assign sb = stage_word[11:8];
    assign sc = stage_word[7:4];
    assign sd = stage_word[3:0];
    assign ratio_w = 8'(8'(sa) * 8'(sb) * 8'(sc) * 8'(sd));

    ////////////////////////////////////////////////////////////////////////
    // divider power and extra feedback divide
    wire logic div_pwr_w;
    wire logic both_vco;
    wire logic mult3;
    wire logic [2:0] extra_calc;
    assign div_pwr_w = (link.first_output_select == cds_pkg::cds_sel_out_divide_code)
        || (link.second_output_select == cds_pkg::cds_sel_out_divide_code)
        || (link.second_output_select == cds_pkg::cds_sel_sysref);
    assign both_vco = (link.first_output_select == cds_pkg::cds_sel_vco)
        && (link.second_output_select == cds_pkg::cds_sel_vco);
    // stage b of 3 marks a multiple of three, except the ratios 24 and 192
    assign mult3 = (sb == 4'h3) && (ratio_w != 8'h18) && (ratio_w != 8'hc0);
    assign extra_calc = both_vco ? 3'h1 : (mult3 ? 3'h6 : 3'h4);

    ////////////////////////////////////////////////////////////////////////
    // output levels
    wire logic pd_now;
    wire logic [5:0] lvl_a_w;
    wire logic [5:0] lvl_b_w;
    function automatic logic [5:0] fold_level(input logic [5:0] code);
        if (code >= `CDS_LVL_DUP_LO && code <= `CDS_LVL_DUP_HI) begin
            return `CDS_LVL_31;
        end
        return code;
    endfunction
    assign pd_now = link.pd_bit | ~link.cal_pin;
    // levels touch only the buffer, never the settling state below
    assign lvl_a_w = pd_now ? 6'h00 : fold_level(link.level_a);
    assign lvl_b_w = pd_now ? 6'h00 : fold_level(link.level_b);

    ////////////////////////////////////////////////////////////////////////
    // sync detection
    logic pin_q, mode_q;
    wire logic pin_edge;
    wire logic mode_edge;
    wire logic sync_evt;
    assign pin_edge = link.sync_pin & ~pin_q & ~link.sync_pin_ignore;
    assign mode_edge = link.phase_mode & ~mode_q;
    assign sync_evt = (pin_edge | mode_edge) & ~pd_now;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_q <= 1'b0;
            mode_q <= 1'b0;
            sync_pulse <= 1'b0;
        end else begin
            pin_q <= link.sync_pin;
            mode_q <= link.phase_mode;
            sync_pulse <= sync_evt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // settling sequence after sync
    cds_pkg::cds_state_t st_q, st_d;
    logic [SEQ_W-1:0] cnt_q, cnt_d;
    wire logic cnt_end;
    assign cnt_end = cnt_q == SEQ_W'(0);

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_end ? cnt_q : cnt_q - SEQ_W'(1);
        case (st_q)
            cds_pkg::cds_st_idle: begin
                st_d = cds_pkg::cds_st_idle;
            end
            cds_pkg::cds_st_cal: begin
                if (cnt_end) begin
                    st_d = cds_pkg::cds_st_settle;
                    cnt_d = SEQ_W'(`CDS_SETTLE_CYC - 1);
                end
            end
            cds_pkg::cds_st_settle: begin
                if (cnt_end && link.frac_mode) begin
                    st_d = cds_pkg::cds_st_modw;
                    cnt_d = SEQ_W'(`CDS_MODW_CYC - 1);
                end else if (cnt_end) begin
                    st_d = cds_pkg::cds_st_done;
                end
            end
            cds_pkg::cds_st_modw: begin
                if (cnt_end) begin
                    st_d = cds_pkg::cds_st_done;
                end
            end
            default: begin
                st_d = cds_pkg::cds_st_done;
            end
        endcase
        // a fresh sync restarts; power-down or mode off drops the phase
        if (sync_pulse) begin
            st_d = cds_pkg::cds_st_cal;
            cnt_d = SEQ_W'(`CDS_CAL_CYC - 1);
        end else if (pd_now || !link.phase_mode) begin
            st_d = cds_pkg::cds_st_idle;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power-down tracking and registered outputs
    logic need_recal_q;
    wire logic leaving_pd;
    assign leaving_pd = device_powered_down & ~pd_now;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= cds_pkg::cds_st_idle;
            cnt_q <= '0;
            need_recal_q <= 1'b0;
            device_powered_down <= 1'b0;
            {stage_a_factor, stage_b_factor, stage_c_factor, stage_d_factor} <= 16'h0000;
            divide_ratio <= 8'h00;
            divider_power <= 1'b0;
            {out_level_a, out_level_b} <= 12'h000;
            feedback_extra_divide <= 3'h1;
            phase_deterministic <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            device_powered_down <= pd_now;
            // set wins over the clearing trigger
            if (leaving_pd) begin
                need_recal_q <= 1'b1;
            end else if (link.band_cal_trigger) begin
                need_recal_q <= 1'b0;
            end
            stage_a_factor <= sa;
            stage_b_factor <= sb;
            stage_c_factor <= sc;
            stage_d_factor <= sd;
            divide_ratio <= ratio_w;
            divider_power <= div_pwr_w & ~pd_now;
            out_level_a <= lvl_a_w;
            out_level_b <= lvl_b_w;
            feedback_extra_divide <= link.phase_mode ? extra_calc : 3'h1;
            phase_deterministic <= st_d == cds_pkg::cds_st_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status back to the controller
    assign link.powered_down = device_powered_down;
    assign link.divider_powered = divider_power;
    assign link.phase_det = phase_deterministic;
    assign link.need_recal = need_recal_q;
    assign link.ratio = divide_ratio;
    assign link.extra_div_calc = extra_calc;
endmodule // cds_device
`default_nettype wire

// File: core/cds_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "cds_defines.svh"
module cds_host (
    input wire logic aclk,
    input wire logic aresetn,
    cds_if.host link,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    ////////////////////////////////////////////////////////////////////////
    // axi4-lite handshakes
    logic aw_have_q, w_have_q;
    logic [31:0] awaddr_q, wdata_q;
    logic [3:0] wstrb_q;
    wire logic aw_fire = s_axi_awvalid & s_axi_awready;
    wire logic w_fire = s_axi_wvalid & s_axi_wready;
    wire logic do_wr = aw_have_q & w_have_q & ~s_axi_bvalid;
    wire logic aw_have_d = aw_fire | (aw_have_q & ~do_wr);
    wire logic w_have_d = w_fire | (w_have_q & ~do_wr);
    wire logic ar_fire = s_axi_arvalid & s_axi_arready;
    wire logic rvalid_d = ar_fire | (s_axi_rvalid & ~s_axi_rready);
    wire logic [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
        {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire logic wr_ctrl = do_wr && awaddr_q == `CDS_OFF_CTRL;
    wire logic wr_level = do_wr && awaddr_q == `CDS_OFF_LEVEL;
    wire logic wr_cmd = do_wr && awaddr_q == `CDS_OFF_CMD;
    wire logic wr_fb = do_wr && awaddr_q == `CDS_OFF_FBINT;
    wire logic wr_stat = do_wr && awaddr_q == `CDS_OFF_STATUS;
    wire logic wr_ok = wr_ctrl | wr_level | wr_cmd | wr_fb | wr_stat;

    ////////////////////////////////////////////////////////////////////////
    // software registers and their steering
    logic [31:0] ctrl_q, level_q;
    logic [15:0] fb_q;
    logic rej_q, pmode_req_q, pd_seen_q;
    wire logic [31:0] ctrl_new = (ctrl_q & ~wmask) | (wdata_q & wmask);
    wire logic [31:0] level_new = (level_q & ~wmask) | (wdata_q & wmask);
    wire logic code_bad = ctrl_new[`CDS_CTRL_CODE] > `CDS_CODE_MAX;
    // a bad code keeps the old one so the divider never sees it
    wire logic [31:0] ctrl_acc = code_bad
        ? {ctrl_new[31:5], ctrl_q[`CDS_CTRL_CODE]} : ctrl_new;
    wire logic [1:0] band = ctrl_q[`CDS_CTRL_BAND];
    wire logic [5:0] cap = (band == 2'h2) ? `CDS_LVL_20
        : ((band == 2'h1 || ctrl_q[`CDS_CTRL_PULLUP]) ? `CDS_LVL_31
        : `CDS_LVL_MAX);
    wire logic [5:0] la = level_q[`CDS_LEVEL_A];
    wire logic [5:0] lb = level_q[`CDS_LEVEL_B];
    wire logic pmode_sw = ctrl_q[`CDS_CTRL_PMODE];
    wire logic [2:0] extra = pmode_sw ? link.extra_div_calc : 3'h1;
    wire logic [31:0] status_w = {16'h0000, rej_q, link.extra_div_calc,
        link.ratio, link.need_recal, link.phase_det, link.divider_powered,
        link.powered_down};
    wire logic [31:0] rdata_w = (s_axi_araddr == `CDS_OFF_CTRL) ? ctrl_q
        : (s_axi_araddr == `CDS_OFF_LEVEL) ? level_q
        : (s_axi_araddr == `CDS_OFF_FBINT) ? {16'h0000, fb_q}
        : (s_axi_araddr == `CDS_OFF_STATUS) ? status_w : 32'h0000_0000;
    wire logic rd_ok = s_axi_araddr == `CDS_OFF_CTRL || s_axi_araddr == `CDS_OFF_LEVEL
        || s_axi_araddr == `CDS_OFF_FBINT || s_axi_araddr == `CDS_OFF_STATUS
        || s_axi_araddr == `CDS_OFF_CMD;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {aw_have_q, w_have_q, wstrb_q} <= 6'h00;
            {awaddr_q, wdata_q, s_axi_rdata} <= 96'h0;
            {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid} <= 5'h00;
            {s_axi_bresp, s_axi_rresp} <= 4'h0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            s_axi_awready <= ~aw_have_d & ~s_axi_bvalid & ~do_wr;
            s_axi_wready <= ~w_have_d & ~s_axi_bvalid & ~do_wr;
            if (aw_fire) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_fire) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= ~rvalid_d;
            s_axi_rvalid <= rvalid_d;
            if (ar_fire) begin
                s_axi_rdata <= rdata_w;
                s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `CDS_CTRL_RST;
            level_q <= `CDS_LEVEL_RST;
            fb_q <= 16'h0000;
            {rej_q, pmode_req_q, pd_seen_q} <= 3'h0;
            link.out_divide_code <= 5'h00;
            link.first_output_select <= cds_pkg::cds_sel_vco;
            link.second_output_select <= cds_pkg::cds_sel_vco;
            {link.level_a, link.level_b} <= 12'h000;
            {link.pd_bit, link.frac_mode, link.phase_mode} <= 3'h0;
            {link.cal_pin, link.sync_pin_ignore} <= 2'h3;
            {link.sync_pin, link.band_cal_trigger} <= 2'h0;
            link.fb_int <= 16'h0000;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= ctrl_acc;
            end
            if (wr_level) begin
                level_q <= level_new;
            end
            if (wr_fb) begin
                fb_q <= wdata_q[15:0];
            end
            // a new rejection wins over a write-one clear
            if (wr_ctrl && code_bad) begin
                rej_q <= 1'b1;
            end else if (wr_stat && wdata_q[`CDS_STAT_REJ]) begin
                rej_q <= 1'b0;
            end
            pd_seen_q <= link.powered_down;
            link.out_divide_code <= ctrl_q[`CDS_CTRL_CODE];
            link.first_output_select <= ctrl_q[`CDS_CTRL_ENA]
                ? cds_pkg::cds_sel_t'(ctrl_q[`CDS_CTRL_SELA]) : cds_pkg::cds_sel_vco;
            link.second_output_select <= ctrl_q[`CDS_CTRL_ENB]
                ? cds_pkg::cds_sel_t'(ctrl_q[`CDS_CTRL_SELB]) : cds_pkg::cds_sel_vco;
            link.level_a <= ctrl_q[`CDS_CTRL_ENA] ? ((la > cap) ? cap : la) : 6'h00;
            link.level_b <= ctrl_q[`CDS_CTRL_ENB] ? ((lb > cap) ? cap : lb) : 6'h00;
            link.pd_bit <= ctrl_q[`CDS_CTRL_PD];
            link.cal_pin <= ctrl_q[`CDS_CTRL_CALPIN];
            link.frac_mode <= ctrl_q[`CDS_CTRL_FRAC];
            // feedback value lands a cycle before the mode bit rises
            link.fb_int <= fb_q / {13'h0000, extra};
            pmode_req_q <= pmode_sw;
            link.phase_mode <= pmode_sw & pmode_req_q;
            link.sync_pin_ignore <= ~(pmode_sw & pmode_req_q);
            link.sync_pin <= wr_cmd & wdata_q[`CDS_CMD_SYNC] & wstrb_q[0];
            link.band_cal_trigger <= (wr_cmd & wdata_q[`CDS_CMD_CAL] & wstrb_q[0])
                | (pd_seen_q & ~link.powered_down);
        end
    end
endmodule // cds_host
`default_nettype wire

// File: tb/cds_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cds_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] out_divide_code,
    input var cds_pkg::cds_sel_t first_output_select,
    input var cds_pkg::cds_sel_t second_output_select,
    input wire logic pd_bit,
    input wire logic cal_pin,
    input wire logic phase_mode,
    input wire logic sync_pin,
    input wire logic band_cal_trigger,
    input wire logic powered_down,
    input wire logic divider_powered,
    input wire logic phase_det,
    input wire logic [7:0] ratio,
    input wire logic [2:0] extra_div_calc
);
    // ratio per code, code 13 in the top byte
    localparam logic [111:0] RT = 112'hc0_80_60_48_40_30_20_18_10_0c_08_06_04_02;
    wire logic need_div = first_output_select == cds_pkg::cds_sel_out_divide_code ||
        second_output_select inside {cds_pkg::cds_sel_out_divide_code, cds_pkg::cds_sel_sysref};
    wire logic both_vco = first_output_select == cds_pkg::cds_sel_vco &&
        second_output_select == cds_pkg::cds_sel_vco;
    wire logic by3 = out_divide_code inside {5'h02, 5'h04, 5'h08, 5'h0a, 5'h0b};
    wire logic [2:0] x_exp = both_vco ? 3'h1 : (by3 ? 3'h6 : 3'h4);
    // saturating count of cycles with phase mode on
    logic [11:0] run_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || !phase_mode || powered_down)
            run_q <= 12'h000;
        else if (run_q != 12'hfff)
            run_q <= run_q + 12'h001;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    chk_code_legal: assert property (out_divide_code <= 5'h0d)
        else $error("illegal divide code on link");
    chk_ratio_table: assert property ($past(aresetn) |->
        ratio == RT[8 * $past(out_divide_code) +: 8])
        else $error("ratio does not match code");
    chk_div_off: assert property ($past(aresetn) && !$past(need_div) |-> !divider_powered)
        else $error("divider powered without a user");
    chk_pd_follow: assert property ($past(aresetn) |->
        powered_down == $past(pd_bit || !cal_pin))
        else $error("power-down state wrong");
    chk_extra_calc: assert property (extra_div_calc == x_exp)
        else $error("extra divide wrong");
    chk_phase_drop: assert property ((!phase_mode || powered_down) |-> ##[1:2] !phase_det)
        else $error("phase flag held without mode");
    chk_phase_wait: assert property ($rose(phase_det) |-> run_q >= 12'd600)
        else $error("phase flag rose too early");
    chk_recal_trig: assert property ($fell(powered_down) |-> ##[0:3] band_cal_trigger)
        else $error("no recalibration after wake");
    chk_sync_short: assert property (sync_pin |=> !sync_pin)
        else $error("sync pin pulse too long");
    cover property ($rose(phase_det));
    cover property ($fell(powered_down));
    cover property (divider_powered && second_output_select == cds_pkg::cds_sel_sysref);
endmodule // cds_asserts
`default_nettype wire

// File: tb/channel_divider_phase_sync_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "cds_defines.svh"
module channel_divider_phase_sync_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, sync_p, div_pwr, dev_pd, ph_det;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    logic [3:0] st_a, st_b, st_c, st_d;
    logic [7:0] div_ratio;
    logic [5:0] lvl_a, lvl_b;
    logic [2:0] fb_x;
    int failures = 0, samples_checked = 0;
    int cyc = 0, sync_seen = 0, sync_at = 0;
    cds_if link_if();
    cds_device u_cds_device (.aclk(aclk), .aresetn(aresetn), .link(link_if.dev),
        .stage_a_factor(st_a), .stage_b_factor(st_b), .stage_c_factor(st_c),
        .stage_d_factor(st_d), .divide_ratio(div_ratio), .divider_power(div_pwr),
        .out_level_a(lvl_a), .out_level_b(lvl_b), .device_powered_down(dev_pd),
        .sync_pulse(sync_p), .feedback_extra_divide(fb_x), .phase_deterministic(ph_det));
    cds_host u_cds_host (.aclk(aclk), .aresetn(aresetn), .link(link_if.host),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    cds_asserts u_cds_asserts (.aclk(aclk), .aresetn(aresetn),
        .out_divide_code(link_if.out_divide_code),
        .first_output_select(link_if.first_output_select),
        .second_output_select(link_if.second_output_select), .pd_bit(link_if.pd_bit),
        .cal_pin(link_if.cal_pin), .phase_mode(link_if.phase_mode),
        .sync_pin(link_if.sync_pin), .band_cal_trigger(link_if.band_cal_trigger),
        .powered_down(link_if.powered_down), .divider_powered(link_if.divider_powered),
        .phase_det(link_if.phase_det), .ratio(link_if.ratio),
        .extra_div_calc(link_if.extra_div_calc));
    always #12.5 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (sync_p === 1'b1) begin
            sync_seen <= sync_seen + 1;
            sync_at <= cyc;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            failures++;
            $display("BAD t=%0t seen %h want %h", $time, seen, want);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // a wait that runs out counts as a mismatch and ends the run
    task give_up(input int n);
        if (n >= 200) begin
            failures++;
            conclude();
        end
        @(posedge aclk);
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        for (n = 0; n < 200 && bvalid !== 1'b1; n++) begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end
        r = bresp;
        bready <= 1'b0;
        give_up(n);
    endtask
    task rd(input logic [31:0] a, output logic [31:0] d);
        int n;
        {araddr, arvalid, rready} <= {a, 2'b11};
        for (n = 0; n < 200 && rvalid !== 1'b1; n++) begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        d = rdata;
        rready <= 1'b0;
        give_up(n);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_regs;
        rd(`CDS_OFF_CTRL, d);
        check(d, 32'h0000_17e0);
        rd(`CDS_OFF_LEVEL, d);
        check(d, 32'h0000_1414);
        wr(32'h0000_0020, 32'h0, r);
        check(r, 2'h2);
        $display("regs done");
    endtask
    // stage tables packed four bits per code, code 0 lowest
    task t_codes;
        logic [55:0] sb, sc, sd;
        int q;
        sb = 56'h32332323232321;
        sc = 56'h88868884422111;
        sd = 56'h44222111111111;
        for (int k = 0; k < 14; k++) begin
            wr(`CDS_OFF_CTRL, 32'h0000_1680 | k, r);
            repeat (4) @(posedge aclk);
            q = 2 * sb[4*k +: 4] * sc[4*k +: 4] * sd[4*k +: 4];
            check({st_a, st_b, st_c, st_d},
                {4'h2, sb[4*k +: 4], sc[4*k +: 4], sd[4*k +: 4]});
            check(div_ratio, q[7:0]);
            check(div_pwr, 1'b1);
            check(link_if.extra_div_calc, (q % 3 == 0 && q != 24 && q != 192) ? 6 : 4);
        end
        wr(`CDS_OFF_CTRL, 32'h0000_168e, r);
        repeat (4) @(posedge aclk);
        check(div_ratio, 8'hc0);
        rd(`CDS_OFF_STATUS, d);
        check(d[15], 1'b1);
        wr(`CDS_OFF_CTRL, 32'h0000_1721, r);
        repeat (4) @(posedge aclk);
        check(div_pwr, 1'b1);
        wr(`CDS_OFF_CTRL, 32'h0000_16a1, r);
        repeat (4) @(posedge aclk);
        check({div_pwr, link_if.extra_div_calc}, {1'b0, 3'h1});
        $display("codes done");
    endtask
    task t_level;
        wr(`CDS_OFF_LEVEL, 32'h0000_3028, r);
        repeat (4) @(posedge aclk);
        check({lvl_a, lvl_b}, {6'h1f, 6'h30});
        wr(`CDS_OFF_LEVEL, 32'h0000_1f2f, r);
        repeat (4) @(posedge aclk);
        check({lvl_a, lvl_b, ph_det}, {6'h1f, 6'h1f, 1'b0});
        wr(`CDS_OFF_CTRL, 32'h0002_16a1, r);
        repeat (4) @(posedge aclk);
        check({lvl_a, lvl_b}, {6'h14, 6'h14});
        $display("level done");
    endtask
    task t_pd;
        for (int k = 0; k < 2; k++) begin
            wr(`CDS_OFF_CTRL, k ? 32'h0000_06a1 : 32'h0000_1ea1, r);
            repeat (4) @(posedge aclk);
            check(dev_pd, 1'b1);
            wr(`CDS_OFF_CTRL, 32'h0000_1681, r);
            repeat (6) @(posedge aclk);
            check({dev_pd, link_if.need_recal}, 2'b00);
        end
        $display("powerdown done");
    endtask
    task t_sync;
        int s0, n;
        s0 = sync_seen;
        wr(`CDS_OFF_CTRL, 32'h0000_7681, r);
        n = 0;
        while (ph_det !== 1'b1 && n < 2000) begin
            @(posedge aclk);
            n++;
        end
        check(n < 2000, 1'b1);
        check(cyc - sync_at >= 680 && cyc - sync_at <= 684, 1'b1);
        check(sync_seen - s0, 32'h1);
        check(fb_x, 3'h4);
        wr(`CDS_OFF_CMD, 32'h0000_0002, r);
        wr(`CDS_OFF_CTRL, 32'h0000_1681, r);
        repeat (4) @(posedge aclk);
        check({ph_det, fb_x}, {1'b0, 3'h1});
        $display("sync done");
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_codes();
        t_level();
        t_pd();
        t_sync();
        conclude();
    end
endmodule // channel_divider_phase_sync_test
`default_nettype wire
